// ### core/vfw_limit_map.sv
`timescale 1ns/10ps
`default_nettype none
module vfw_limit_map #(
   parameter logic [15:0] MIN_PM = 16'h0400,
   parameter logic [15:0] MAX_PM = 16'h0500,
   parameter logic [15:0] STEP_PM = 16'h000a,
   parameter logic ROUND_UP = 1'b1
) (
   // requested limit in, hardware step out
   vfw_map_if.mapper m
);
   always_comb begin
      logic [15:0] off;
      off = m.req - MIN_PM;
      if (ROUND_UP) begin
         m.ok = (m.req <= MAX_PM);
         if (m.req <= MIN_PM) begin
            m.hw = MIN_PM;
         end else begin
            m.hw = MIN_PM + ((off + STEP_PM - 16'h1) / STEP_PM) * STEP_PM;
         end
      end else begin
         m.ok = (m.req >= MIN_PM);
         if (m.req >= MAX_PM) begin
            m.hw = MAX_PM;
         end else begin
            m.hw = MIN_PM + (off / STEP_PM) * STEP_PM;
         end
      end
      if (!m.ok) begin
         m.hw = MIN_PM;
      end
   end
endmodule : vfw_limit_map
`default_nettype wire

// ### core/vfw_map_if.sv
`timescale 1ns/10ps
`default_nettype none
interface vfw_map_if;
   logic [15:0] req;
   logic [15:0] hw;
   logic ok;
   modport mapper (input req, output hw, output ok);
   modport user (output req, input hw, input ok);
endinterface : vfw_map_if
`default_nettype wire

// ### core/vfw_pkg.sv
package vfw_pkg;
   // command codes
   localparam logic [7:0] CMD_OVF_LIMIT = 8'h40;
   localparam logic [7:0] CMD_OV_ACTION = 8'h41;
   localparam logic [7:0] CMD_OVW_LIMIT = 8'h42;
   localparam logic [7:0] CMD_UVW_LIMIT = 8'h43;
   localparam logic [7:0] CMD_UVF_LIMIT = 8'h44;
   localparam logic [7:0] CMD_UV_ACTION = 8'h45;
   localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
   localparam logic [7:0] CMD_STAT_WORD = 8'h79;
   localparam logic [7:0] CMD_STAT_VOUT = 8'h7a;
   localparam logic [7:0] CMD_STAT_CML = 8'h7e;
   // action byte fields
   localparam int ACT_SEL_HI = 7;
   localparam int ACT_SEL_LO = 6;
   localparam int ACT_RETRY_HI = 5;
   localparam int ACT_RETRY_LO = 3;
   localparam int ACT_DLY_HI = 2;
   localparam int ACT_DLY_LO = 0;
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_SHUT_A = 2'h1;
   localparam logic [1:0] ACT_SHUT_B = 2'h2;
   localparam logic [1:0] ACT_INVALID = 2'h3;
   localparam logic [2:0] RETRY_LATCH = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // status bit positions
   localparam int SB_OV_FAULT = 5;
   localparam int SB_CML = 1;
   localparam int SB_NOTA = 0;
   localparam int SV_OV_FAULT = 7;
   localparam int SV_OV_WARN = 6;
   localparam int SV_UV_WARN = 5;
   localparam int SV_UV_FAULT = 4;
   localparam int CML_BAD_CMD = 7;
   localparam int CML_BAD_DATA = 6;
   // undervoltage shutdown delays in switching cycles
   localparam logic [19:0] UV_DLY_ONE = 20'h1;
   localparam logic [19:0] UV_DLY_THREE = 20'h3;
   localparam logic [19:0] UV_DLY_SEVEN = 20'h7;
   localparam logic [2:0] UV_DLY_CODE_MID = 3'h2;
   localparam logic [2:0] UV_DLY_CODE_LONG = 3'h5;
   // limits are per mille of the output target
   localparam logic [31:0] PM_SCALE = 32'h3e8;
   localparam int MAP_N = 5;
   localparam int MAP_OVF = 0;
   localparam int MAP_OVF_OFF = 1;
   localparam int MAP_OVW = 2;
   localparam int MAP_UVW = 3;
   localparam int MAP_UVF = 4;
   localparam logic [15:0] MAP_MIN [MAP_N] = '{16'h041a, 16'h044c, 16'h0406, 16'h0348, 16'h0258};
   localparam logic [15:0] MAP_MAX [MAP_N] = '{16'h0578, 16'h0578, 16'h0488, 16'h03ca, 16'h03b6};
   localparam logic [15:0] MAP_STEP [MAP_N] = '{16'h0019, 16'h0064, 16'h000a, 16'h000a, 16'h0019};
   localparam logic MAP_UP [MAP_N] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   // reset values until the nonvolatile copy is taken
   localparam logic [15:0] RST_OVF_LIMIT = 16'h047e;
   localparam logic [15:0] RST_OVF_OFF_HW = 16'h04b0;
   localparam logic [15:0] RST_OVW_LIMIT = 16'h044c;
   localparam logic [15:0] RST_UVW_LIMIT = 16'h0384;
   localparam logic [15:0] RST_UVF_LIMIT = 16'h0320;
   localparam logic [7:0] RST_OV_ACTION = 8'h80;
   localparam logic [7:0] RST_UV_ACTION = 8'h80;

   typedef enum logic [2:0] {
      ST_OFF, ST_RISE, ST_CHECK, ST_ON, ST_UV_WAIT, ST_RESTART_WAIT_PERIOD, ST_LATCHED
   } vfw_state_t;

   typedef struct packed {
      logic [15:0] ovf_lim, ovw_lim, uvw_lim, uvf_lim;
      logic [15:0] ovf_hw, ovf_off_hw, ovw_hw, uvw_hw, uvf_hw;
      logic [7:0] ov_act, uv_act;
      vfw_state_t st;
      logic [19:0] cnt;
      logic [2:0] tries;
      logic [7:0] stat_byte, stat_vout, stat_cml;
      logic stat_word_vout;
      logic load_pend;
      logic pwr_en;
      logic alert_n;
      logic [15:0] rdata;
   } vfw_regs_t;
endpackage : vfw_pkg

// ### core/vfw_vout_supervisor.sv
// Operation
// - ov action: ignore, shutdown-retry, or invalid
// - ov retry: latch, limited tries, or forever
// - ov restart_wait_period equals code times rise time, code 0 one rise time
// - invalid written values flag status, alert host
// - quiet check window after rise clears tries
// - limits act as per mille of present target
// - ov warning 103-116 percent, round up
// - ov warning sets vout bits, alerts
// - uv warning 84-97 percent, round down
// - uv warning sets vout bits, alerts
// - uv fault 60-95 percent, round down
// - uv fault sets status bits, alerts
// - uv action: ignore, delayed, immediate, invalid
// - uv retry: latch, limited tries, or forever
// - uv delay one/three/seven cycles, restart_wait_period multiple
// - ov fault sets status bits, alerts
// - ov fault 105-140 percent, coarser when off
`timescale 1ns/10ps
`default_nettype none
module vfw_vout_supervisor
   import vfw_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // command port
   input wire logic i_wr_valid,
   input wire logic [7:0] i_wr_code,
   input wire logic [15:0] i_wr_data,
   input wire logic [7:0] i_rd_code,
   input wire logic i_clear_faults,
   // nonvolatile copy, taken once after reset
   input wire logic [15:0] i_nvm_ovf_limit,
   input wire logic [15:0] i_nvm_ovw_limit,
   input wire logic [15:0] i_nvm_uvw_limit,
   input wire logic [15:0] i_nvm_uvf_limit,
   input wire logic [7:0] i_nvm_ov_action,
   input wire logic [7:0] i_nvm_uv_action,
   // converter
   input wire logic [15:0] i_vout_sense,
   input wire logic [15:0] i_vout_target,
   input wire logic [15:0] i_rise_cycles,
   input wire logic [15:0] i_startup_limit_cycles,
   input wire logic i_cmd_on,
   // outputs
   output logic [15:0] o_rd_data,
   output logic o_power_enable,
   output logic o_alert_n
);
   vfw_regs_t q;
   vfw_regs_t d;
   logic [15:0] map_req [MAP_N];
   logic [15:0] map_hw [MAP_N];
   logic [MAP_N-1:0] map_ok;
   logic [15:0] nvm_lim [MAP_N];
   logic wr_ok;
   logic wr_known;
   logic [31:0] sense_pm;
   logic [15:0] ovf_sel;
   logic converting;
   logic ov_flt;
   logic ov_warn;
   logic uv_warn;
   logic uv_flt;
   logic do_shut;
   logic shut_uv;
   logic [2:0] retry;
   logic [15:0] window;

   function automatic logic [19:0] minus1(input logic [19:0] x);
      return (x == 20'h0) ? 20'h0 : x - 20'h1;
   endfunction : minus1

   function automatic logic [19:0] hic_len(input logic [2:0] code, input logic [15:0] rise);
      logic [2:0] mult;
      mult = (code <= 3'h1) ? 3'h1 : code;
      return {4'h0, rise} * {17'h0, mult};
   endfunction : hic_len

   function automatic logic [19:0] uv_delay(input logic [2:0] code);
      if (code >= UV_DLY_CODE_LONG) begin
         return UV_DLY_SEVEN;
      end else if (code >= UV_DLY_CODE_MID) begin
         return UV_DLY_THREE;
      end
      return UV_DLY_ONE;
   endfunction : uv_delay

   assign nvm_lim[MAP_OVF] = i_nvm_ovf_limit;
   assign nvm_lim[MAP_OVF_OFF] = i_nvm_ovf_limit;
   assign nvm_lim[MAP_OVW] = i_nvm_ovw_limit;
   assign nvm_lim[MAP_UVW] = i_nvm_uvw_limit;
   assign nvm_lim[MAP_UVF] = i_nvm_uvf_limit;

   for (genvar g = 0; g < MAP_N; g++) begin : g_map
      vfw_map_if map_if ();
      assign map_req[g] = q.load_pend ? nvm_lim[g] : i_wr_data;
      assign map_if.req = map_req[g];
      assign map_hw[g] = map_if.hw;
      assign map_ok[g] = map_if.ok;
      vfw_limit_map #(
         .MIN_PM(MAP_MIN[g]),
         .MAX_PM(MAP_MAX[g]),
         .STEP_PM(MAP_STEP[g]),
         .ROUND_UP(MAP_UP[g])
      ) u_map (
         .m(map_if.mapper)
      );
   end

   always_comb begin
      wr_known = 1'b1;
      wr_ok = 1'b1;
      case (i_wr_code)
         CMD_OVF_LIMIT: wr_ok = map_ok[MAP_OVF];
         CMD_OV_ACTION: wr_ok = (i_wr_data[ACT_SEL_HI:ACT_SEL_LO] != ACT_INVALID);
         CMD_OVW_LIMIT: wr_ok = map_ok[MAP_OVW];
         CMD_UVW_LIMIT: wr_ok = map_ok[MAP_UVW];
         CMD_UVF_LIMIT: wr_ok = map_ok[MAP_UVF];
         CMD_UV_ACTION: wr_ok = (i_wr_data[ACT_SEL_HI:ACT_SEL_LO] != ACT_INVALID);
         default: begin
            wr_known = 1'b0;
            wr_ok = 1'b0;
         end
      endcase
   end

   // thresholds follow the live target, stored words are never rewritten
   assign converting = (q.st == ST_RISE) || (q.st == ST_CHECK) || (q.st == ST_ON) || (q.st == ST_UV_WAIT);
   assign ovf_sel = converting ? q.ovf_hw : q.ovf_off_hw;
   assign sense_pm = {16'h0, i_vout_sense} * PM_SCALE;
   assign ov_flt = sense_pm > {16'h0, i_vout_target} * {16'h0, ovf_sel};
   assign ov_warn = sense_pm > {16'h0, i_vout_target} * {16'h0, q.ovw_hw};
   assign uv_warn = (q.st == ST_ON) && (sense_pm < {16'h0, i_vout_target} * {16'h0, q.uvw_hw});
   assign uv_flt = ((q.st == ST_ON) || (q.st == ST_CHECK) || (q.st == ST_UV_WAIT))
                   && (sense_pm < {16'h0, i_vout_target} * {16'h0, q.uvf_hw});
   assign window = (i_startup_limit_cycles != 16'h0) ? i_startup_limit_cycles : i_rise_cycles;

   always_comb begin
      d = q;
      do_shut = 1'b0;
      shut_uv = 1'b0;
      retry = 3'h0;
      // configuration load and writes
      if (q.load_pend) begin
         d.load_pend = 1'b0;
         if (map_ok[MAP_OVF]) begin
            d.ovf_lim = i_nvm_ovf_limit;
            d.ovf_hw = map_hw[MAP_OVF];
            d.ovf_off_hw = map_hw[MAP_OVF_OFF];
         end
         if (map_ok[MAP_OVW]) begin
            d.ovw_lim = i_nvm_ovw_limit;
            d.ovw_hw = map_hw[MAP_OVW];
         end
         if (map_ok[MAP_UVW]) begin
            d.uvw_lim = i_nvm_uvw_limit;
            d.uvw_hw = map_hw[MAP_UVW];
         end
         if (map_ok[MAP_UVF]) begin
            d.uvf_lim = i_nvm_uvf_limit;
            d.uvf_hw = map_hw[MAP_UVF];
         end
         if (i_nvm_ov_action[ACT_SEL_HI:ACT_SEL_LO] != ACT_INVALID) begin
            d.ov_act = i_nvm_ov_action;
         end
         if (i_nvm_uv_action[ACT_SEL_HI:ACT_SEL_LO] != ACT_INVALID) begin
            d.uv_act = i_nvm_uv_action;
         end
      end else if (i_wr_valid && wr_ok) begin
         case (i_wr_code)
            CMD_OVF_LIMIT: begin
               d.ovf_lim = i_wr_data;
               d.ovf_hw = map_hw[MAP_OVF];
               d.ovf_off_hw = map_hw[MAP_OVF_OFF];
            end
            CMD_OV_ACTION: d.ov_act = i_wr_data[7:0];
            CMD_OVW_LIMIT: begin
               d.ovw_lim = i_wr_data;
               d.ovw_hw = map_hw[MAP_OVW];
            end
            CMD_UVW_LIMIT: begin
               d.uvw_lim = i_wr_data;
               d.uvw_hw = map_hw[MAP_UVW];
            end
            CMD_UVF_LIMIT: begin
               d.uvf_lim = i_wr_data;
               d.uvf_hw = map_hw[MAP_UVF];
            end
            CMD_UV_ACTION: d.uv_act = i_wr_data[7:0];
            default: d.rdata = q.rdata;
         endcase
      end
      // restart sequencing
      case (q.st)
         ST_OFF: begin
            if (i_cmd_on) begin
               d.st = ST_RISE;
               d.cnt = minus1({4'h0, i_rise_cycles});
               d.pwr_en = 1'b1;
               d.tries = 3'h0;
            end
         end
         ST_RISE: begin
            if (q.cnt == 20'h0) begin
               d.st = ST_CHECK;
               d.cnt = minus1({4'h0, window});
            end else begin
               d.cnt = q.cnt - 20'h1;
            end
         end
         ST_CHECK: begin
            if (q.cnt == 20'h0) begin
               d.st = ST_ON;
               d.tries = 3'h0;
            end else begin
               d.cnt = q.cnt - 20'h1;
            end
         end
         ST_UV_WAIT: begin
            if (q.cnt == 20'h0) begin
               do_shut = 1'b1;
               shut_uv = 1'b1;
            end else begin
               d.cnt = q.cnt - 20'h1;
            end
         end
         ST_RESTART_WAIT_PERIOD: begin
            if (q.cnt == 20'h0) begin
               d.st = ST_RISE;
               d.cnt = minus1({4'h0, i_rise_cycles});
               d.pwr_en = 1'b1;
            end else begin
               d.cnt = q.cnt - 20'h1;
            end
         end
         ST_ON, ST_LATCHED: d.st = q.st;
         default: d.st = ST_OFF;
      endcase
      // fault responses
      if (converting && ov_flt && (q.ov_act[ACT_SEL_HI:ACT_SEL_LO] != ACT_IGNORE)) begin
         do_shut = 1'b1;
         shut_uv = 1'b0;
      end else if (uv_flt && (q.uv_act[ACT_SEL_HI:ACT_SEL_LO] == ACT_SHUT_B)) begin
         do_shut = 1'b1;
         shut_uv = 1'b1;
      end else if (uv_flt && (q.st != ST_UV_WAIT) && (q.uv_act[ACT_SEL_HI:ACT_SEL_LO] == ACT_SHUT_A)) begin
         d.st = ST_UV_WAIT;
         d.cnt = minus1(uv_delay(q.uv_act[ACT_DLY_HI:ACT_DLY_LO]));
      end
      if (do_shut) begin
         retry = shut_uv ? q.uv_act[ACT_RETRY_HI:ACT_RETRY_LO] : q.ov_act[ACT_RETRY_HI:ACT_RETRY_LO];
         d.pwr_en = 1'b0;
         if ((retry == RETRY_FOREVER) || (q.tries < retry)) begin
            d.st = ST_RESTART_WAIT_PERIOD;
            d.tries = (retry == RETRY_FOREVER) ? q.tries : q.tries + 3'h1;
            d.cnt = minus1(hic_len(shut_uv ? q.uv_act[ACT_DLY_HI:ACT_DLY_LO]
                                            : q.ov_act[ACT_DLY_HI:ACT_DLY_LO], i_rise_cycles));
         end else begin
            d.st = ST_LATCHED;
         end
      end
      if (!i_cmd_on && (q.st != ST_OFF)) begin
         d.st = ST_OFF;
         d.pwr_en = 1'b0;
         d.tries = 3'h0;
         d.cnt = 20'h0;
      end
      // sticky status, a set in the clearing cycle wins
      if (i_clear_faults) begin
         d.stat_byte = 8'h0;
         d.stat_vout = 8'h0;
         d.stat_cml = 8'h0;
         d.stat_word_vout = 1'b0;
      end
      if (ov_flt) begin
         d.stat_byte[SB_OV_FAULT] = 1'b1;
         d.stat_word_vout = 1'b1;
         d.stat_vout[SV_OV_FAULT] = 1'b1;
      end
      if (ov_warn) begin
         d.stat_word_vout = 1'b1;
         d.stat_vout[SV_OV_WARN] = 1'b1;
      end
      if (uv_warn) begin
         d.stat_word_vout = 1'b1;
         d.stat_vout[SV_UV_WARN] = 1'b1;
      end
      if (uv_flt) begin
         d.stat_byte[SB_NOTA] = 1'b1;
         d.stat_word_vout = 1'b1;
         d.stat_vout[SV_UV_FAULT] = 1'b1;
      end
      if (i_wr_valid && !q.load_pend && !wr_ok) begin
         d.stat_byte[SB_CML] = 1'b1;
         d.stat_word_vout = q.stat_word_vout | d.stat_word_vout;
         if (wr_known) begin
            d.stat_cml[CML_BAD_DATA] = 1'b1;
         end else begin
            d.stat_cml[CML_BAD_CMD] = 1'b1;
         end
      end
      d.alert_n = ~((|d.stat_byte) | (|d.stat_vout) | (|d.stat_cml) | d.stat_word_vout);
      case (i_rd_code)
         CMD_OVF_LIMIT: d.rdata = q.ovf_lim;
         CMD_OV_ACTION: d.rdata = {8'h0, q.ov_act};
         CMD_OVW_LIMIT: d.rdata = q.ovw_lim;
         CMD_UVW_LIMIT: d.rdata = q.uvw_lim;
         CMD_UVF_LIMIT: d.rdata = q.uvf_lim;
         CMD_UV_ACTION: d.rdata = {8'h0, q.uv_act};
         CMD_STAT_BYTE: d.rdata = {8'h0, q.stat_byte};
         CMD_STAT_WORD: d.rdata = {q.stat_word_vout, 7'h0, q.stat_byte};
         CMD_STAT_VOUT: d.rdata = {8'h0, q.stat_vout};
         CMD_STAT_CML: d.rdata = {8'h0, q.stat_cml};
         default: d.rdata = 16'h0;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '{ovf_lim: RST_OVF_LIMIT, ovw_lim: RST_OVW_LIMIT, uvw_lim: RST_UVW_LIMIT,
                uvf_lim: RST_UVF_LIMIT, ovf_hw: RST_OVF_LIMIT, ovf_off_hw: RST_OVF_OFF_HW,
                ovw_hw: RST_OVW_LIMIT, uvw_hw: RST_UVW_LIMIT, uvf_hw: RST_UVF_LIMIT,
                ov_act: RST_OV_ACTION, uv_act: RST_UV_ACTION, st: ST_OFF, load_pend: 1'b1,
                alert_n: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   assign o_rd_data = q.rdata;
   assign o_power_enable = q.pwr_en;
   assign o_alert_n = q.alert_n;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_uv_delayed_start;
      (q.st == ST_ON) && uv_flt && !ov_flt && i_cmd_on && (q.uv_act[ACT_SEL_HI:ACT_SEL_LO] == ACT_SHUT_A);
   endsequence
   sequence s_check_done;
      (q.st == ST_CHECK) && (q.cnt == 20'h0) && !do_shut && i_cmd_on
         && !(uv_flt && (q.uv_act[ACT_SEL_HI:ACT_SEL_LO] == ACT_SHUT_A));
   endsequence

   a_ov_ignore_runs: assert property ((q.st == ST_ON) && ov_flt && !uv_flt && i_cmd_on
      && (q.ov_act[ACT_SEL_HI:ACT_SEL_LO] == ACT_IGNORE) |=> q.pwr_en)
      else $error("ov fault with ignore stopped the output");
   a_ov_shut_off: assert property ((q.st == ST_ON) && ov_flt
      && (q.ov_act[ACT_SEL_HI:ACT_SEL_LO] != ACT_IGNORE) |=> !q.pwr_en)
      else $error("ov fault did not shut the output");
   a_retry_exhausted: assert property (do_shut && i_cmd_on && (retry != RETRY_FOREVER)
      && (q.tries >= retry) |=> (q.st == ST_LATCHED) && !q.pwr_en)
      else $error("retries exhausted but output not latched off");
   a_restart_wait_period_restart: assert property ((q.st == ST_RESTART_WAIT_PERIOD) && (q.cnt == 20'h0) && i_cmd_on
      |=> (q.st == ST_RISE) && q.pwr_en)
      else $error("restart_wait_period end did not restart");
   a_bad_write_flag: assert property (i_wr_valid && !q.load_pend && !wr_ok
      |=> q.stat_byte[SB_CML] && !q.alert_n)
      else $error("invalid write not flagged");
   a_start_success: assert property (s_check_done |=> (q.st == ST_ON) && (q.tries == 3'h0))
      else $error("successful start did not clear tries");
   a_ovw_range: assert property ((q.ovw_hw >= MAP_MIN[MAP_OVW]) && (q.ovw_hw <= MAP_MAX[MAP_OVW]))
      else $error("ov warning step out of range");
   a_uvf_range: assert property ((q.uvf_hw >= MAP_MIN[MAP_UVF]) && (q.uvf_hw <= MAP_MAX[MAP_UVF]))
      else $error("uv fault step out of range");
   a_ovw_status: assert property (ov_warn |=> q.stat_vout[SV_OV_WARN] && q.stat_word_vout ##0 !q.alert_n)
      else $error("ov warning not reported");
   a_uvf_status: assert property (uv_flt |=> q.stat_vout[SV_UV_FAULT] && q.stat_byte[SB_NOTA])
      else $error("uv fault not reported");
   a_ovf_status: assert property (ov_flt |=> q.stat_vout[SV_OV_FAULT] && q.stat_byte[SB_OV_FAULT])
      else $error("ov fault not reported");
   a_status_sticky: assert property (q.stat_vout[SV_UV_WARN] && !i_clear_faults
      |=> q.stat_vout[SV_UV_WARN])
      else $error("uv warning bit cleared by itself");
   a_reject_keeps: assert property (i_wr_valid && !q.load_pend && !wr_ok
      |=> $stable(q.ovw_lim) && $stable(q.ovw_hw) && $stable(q.uv_act) && $stable(q.ov_act))
      else $error("rejected write changed stored state");
   a_uv_delay_shut: assert property (s_uv_delayed_start |-> ##[1:9] !q.pwr_en)
      else $error("delayed uv shutdown late");
endmodule : vfw_vout_supervisor
`default_nettype wire

// ### verif/tb_vfw_vout_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module tb_vfw_vout_supervisor;
   import vfw_pkg::*;
   logic clk, rst_n, wr_v, clr, cmd_on, pwr, alert_n;
   logic [7:0] wr_c, rd_c;
   logic [15:0] wr_d, level, sense, rd_d, tgt;
   logic [7:0] cd [6] = '{CMD_OVF_LIMIT, CMD_OV_ACTION, CMD_OVW_LIMIT, CMD_UVW_LIMIT, CMD_UVF_LIMIT, CMD_UV_ACTION};
   logic [15:0] nv [6] = '{16'h04b0, 16'h0080, 16'h0460, 16'h0370, 16'h02bc, 16'h0090};
   logic [15:0] good [6] = '{16'h0578, 16'h0040, 16'h0447, 16'h034d, 16'h0258, 16'h0088};
   logic [15:0] bad [6] = '{16'h0579, 16'h00c0, 16'h0489, 16'h0347, 16'h0257, 16'h00c0};
   int n_mismatch = 0;
   int num_checks = 0;

   vfw_vout_supervisor u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_wr_valid(wr_v), .i_wr_code(wr_c),
      .i_wr_data(wr_d), .i_rd_code(rd_c), .i_clear_faults(clr), .i_nvm_ovf_limit(nv[0]),
      .i_nvm_ovw_limit(nv[2]), .i_nvm_uvw_limit(nv[3]), .i_nvm_uvf_limit(nv[4]),
      .i_nvm_ov_action(nv[1][7:0]), .i_nvm_uv_action(nv[5][7:0]), .i_vout_sense(sense),
      .i_vout_target(tgt), .i_rise_cycles(16'h0014), .i_startup_limit_cycles(16'h0000),
      .i_cmd_on(cmd_on), .o_rd_data(rd_d), .o_power_enable(pwr), .o_alert_n(alert_n));

   vfw_plant_model u_plant (.i_clock(clk), .i_power_enable(pwr), .i_level(level), .o_sense(sense));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      wr_v <= 1'b1;
      wr_c <= c;
      wr_d <= d;
      @(posedge clk);
      wr_v <= 1'b0;
   endtask : wr

   // exp is given already masked
   task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic [15:0] m);
      @(posedge clk);
      rd_c <= c;
      @(posedge clk);
      #1;
      chk($sformatf("read code %h", c), exp, rd_d & m);
   endtask : rd

   task automatic clear();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask : clear

   task automatic wait_pwr(input logic v, input int lim);
      int k;
      for (k = 0; k < lim && pwr !== v; k++) begin
         @(posedge clk);
         #1;
      end
      chk("power enable", {15'h0000, v}, {15'h0000, pwr});
      if (pwr !== v) give_verdict();
   endtask : wait_pwr

   initial begin
      rst_n = 1'b0;
      wr_v = 1'b0;
      wr_c = 8'h00;
      wr_d = 16'h0000;
      rd_c = CMD_STAT_BYTE;
      clr = 1'b0;
      cmd_on = 1'b0;
      level = 16'h03e8;
      tgt = 16'h03e8;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 6; i++) rd(cd[i], nv[i], 16'hffff);
      for (int i = 0; i < 6; i++) begin
         wr(cd[i], good[i]);
         rd(cd[i], good[i], 16'hffff);
      end
      // out-of-range values and the reserved action select
      for (int i = 0; i < 6; i++) begin
         wr(cd[i], bad[i]);
         rd(cd[i], good[i], 16'hffff);
         rd(CMD_STAT_CML, 16'h0040, 16'hffff);
         rd(CMD_STAT_BYTE, 16'h0002, 16'hffff);
         chk("alert", 16'h0000, {15'h0000, alert_n});
         clear();
      end
      wr(8'h50, 16'h0000);
      rd(CMD_STAT_CML, 16'h0080, 16'hffff);
      clear();
      repeat (2) @(posedge clk);
      #1;
      chk("alert", 16'h0001, {15'h0000, alert_n});
      // start up and reach the on state
      @(posedge clk);
      cmd_on <= 1'b1;
      wait_pwr(1'b1, 5);
      repeat (60) @(posedge clk);
      rd(CMD_STAT_VOUT, 16'h0000, 16'hffff);
      // overvoltage warning, then output back in range
      level <= 16'h0451;
      repeat (4) @(posedge clk);
      level <= 16'h03e8;
      rd(CMD_STAT_VOUT, 16'h0040, 16'hffff);
      rd(CMD_STAT_WORD, 16'h8000, 16'hffff);
      chk("alert", 16'h0000, {15'h0000, alert_n});
      clear();
      rd(CMD_STAT_VOUT, 16'h0000, 16'hffff);
      level <= 16'h033e;
      repeat (4) @(posedge clk);
      level <= 16'h03e8;
      rd(CMD_STAT_VOUT, 16'h0020, 16'hffff);
      clear();
      // undervoltage fault: immediate shutdown, one restart, then latched
      level <= 16'h01f4;
      wait_pwr(1'b0, 5);
      wait_pwr(1'b1, 60);
      wait_pwr(1'b0, 60);
      repeat (100) @(posedge clk);
      wait_pwr(1'b0, 1);
      rd(CMD_STAT_BYTE, 16'h0001, 16'h0001);
      rd(CMD_STAT_VOUT, 16'h0010, 16'h0010);
      rd(CMD_STAT_WORD, 16'h8000, 16'h8000);
      // overvoltage fault with restart count zero
      cmd_on <= 1'b0;
      level <= 16'h03e8;
      repeat (3) @(posedge clk);
      clear();
      cmd_on <= 1'b1;
      wait_pwr(1'b1, 5);
      repeat (60) @(posedge clk);
      level <= 16'h05dc;
      wait_pwr(1'b0, 5);
      repeat (100) @(posedge clk);
      wait_pwr(1'b0, 1);
      rd(CMD_STAT_BYTE, 16'h0020, 16'h0020);
      rd(CMD_STAT_VOUT, 16'h0080, 16'h0080);
      // ignored overvoltage against a rounded-up step and a live target
      cmd_on <= 1'b0;
      level <= 16'h03e8;
      wr(CMD_OV_ACTION, 16'h0000);
      wr(CMD_OVF_LIMIT, 16'h041b);
      wr(CMD_UV_ACTION, 16'h007a);
      clear();
      cmd_on <= 1'b1;
      wait_pwr(1'b1, 5);
      repeat (60) @(posedge clk);
      level <= 16'h0433;
      repeat (3) @(posedge clk);
      rd(CMD_STAT_VOUT, 16'h0000, 16'h0080);
      tgt <= 16'h03e7;
      repeat (3) @(posedge clk);
      #1;
      chk("power enable", 16'h0001, {15'h0000, pwr});
      rd(CMD_STAT_VOUT, 16'h0080, 16'h0080);
      rd(CMD_OVF_LIMIT, 16'h041b, 16'hffff);
      // delayed undervoltage shutdown of three cycles, then two-rise hiccups without end
      tgt <= 16'h03e8;
      level <= 16'h03e8;
      @(posedge clk);
      level <= 16'h01f4;
      repeat (4) @(posedge clk);
      #1;
      chk("power enable", 16'h0001, {15'h0000, pwr});
      @(posedge clk);
      #1;
      chk("power enable", 16'h0000, {15'h0000, pwr});
      repeat (39) @(posedge clk);
      #1;
      chk("power enable", 16'h0000, {15'h0000, pwr});
      @(posedge clk);
      #1;
      chk("power enable", 16'h0001, {15'h0000, pwr});
      wait_pwr(1'b0, 30);
      wait_pwr(1'b1, 45);
      level <= 16'h03e8;
      repeat (60) @(posedge clk);
      wait_pwr(1'b1, 1);
      give_verdict();
   end
endmodule : tb_vfw_vout_supervisor
`default_nettype wire

// ### verif/vfw_plant_model.sv
`timescale 1ns/10ps
`default_nettype none
module vfw_plant_model (
   // power stage
   input wire logic i_clock,
   input wire logic i_power_enable,
   input wire logic [15:0] i_level,
   // sensed output
   output logic [15:0] o_sense
);
   // output collapses to zero on the first clock edge after the stage is disabled
   always_ff @(posedge i_clock) begin
      o_sense <= i_power_enable ? i_level : 16'h0000;
   end
endmodule : vfw_plant_model
`default_nettype wire
